// *** jtsp_defs.svh ***
// Constants of the pin ring test access port: codes, widths, cell indices.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef JTSP_DEFS_SVH
`define JTSP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register sizes
// ----------------------------------------------------------------------------
`define JTSP_IR_WIDTH       3
`define JTSP_ID_WIDTH       32
`define JTSP_BSR_LENGTH     107
`define JTSP_BSR_OE_CELL    47

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define JTSP_INS_EXTERNAL   3'h0
`define JTSP_INS_IDENT      3'h1
`define JTSP_INS_SAMPLE_HIZ 3'h2
`define JTSP_INS_SAMPLE     3'h4
`define JTSP_INS_SKIP       3'h7
`define JTSP_IR_CAPTURE     3'h1

// ----------------------------------------------------------------------------
// Identification fields (values arbitrary, not of any real part)
// ----------------------------------------------------------------------------
`define JTSP_ID_REVISION    3'h2
`define JTSP_ID_PART        17'h0a5c3
`define JTSP_ID_MAKER       11'h15a

// ----------------------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------------------
`define JTSP_TCK_MIN_NS     100
`define JTSP_CLK_NS         5
`define JTSP_TCK_MIN_CYC    ((`JTSP_TCK_MIN_NS + `JTSP_CLK_NS - 1) / `JTSP_CLK_NS)

`endif

// *** jtsp_pkg.sv ***
// Types of the pin ring test access port.
// Assumes jtsp_defs.svh is on the include path.
`default_nettype none
`include "jtsp_defs.svh"

package jtsp_pkg;

  // Sixteen states of the test access port controller
  typedef enum logic [3:0] {
    JTSP_RESET      = 4'h0,
    JTSP_IDLE       = 4'h1,
    JTSP_SEL_DR     = 4'h2,
    JTSP_CAP_DR     = 4'h3,
    JTSP_SHIFT_DR   = 4'h4,
    JTSP_EXIT1_DR   = 4'h5,
    JTSP_PAUSE_DR   = 4'h6,
    JTSP_EXIT2_DR   = 4'h7,
    JTSP_UPD_DR     = 4'h8,
    JTSP_SEL_IR     = 4'h9,
    JTSP_CAP_IR     = 4'ha,
    JTSP_SHIFT_IR   = 4'hb,
    JTSP_EXIT1_IR   = 4'hc,
    JTSP_PAUSE_IR   = 4'hd,
    JTSP_EXIT2_IR   = 4'he,
    JTSP_UPD_IR     = 4'hf
  } jtsp_state_t;

  // State of the link clock side
  typedef struct packed {
    jtsp_state_t                   state;
    logic [`JTSP_IR_WIDTH-1:0]     irShift;
    logic [`JTSP_IR_WIDTH-1:0]     irActive;
    logic                          skipBit;
    logic [`JTSP_ID_WIDTH-1:0]     idShift;
    logic [`JTSP_BSR_LENGTH-1:0]   bsrShift;
    logic [`JTSP_BSR_LENGTH-1:0]   bsrLatch;
  } jtsp_link_t;

  // State of the system clock side
  typedef struct packed {
    logic [2:0] hizSync;
    logic       outHiz;
    logic [2:0] oeSync;
    logic       outDrive;
  } jtsp_sys_t;

endpackage

`default_nettype wire

// *** jtsp_xfer_if.sv ***
// Interface between the link side core and the system side top.
// Assumes both ends live in this design.
`timescale 1ns/100ps
`default_nettype none

interface jtsp_xfer_if;
  logic extestHiz;   // Level: output bus forced high impedance
  logic extestOe;    // Level: cell 47 drive under external test

  modport link (output extestHiz, output extestOe);
  modport sys  (input  extestHiz, input  extestOe);
endinterface

`default_nettype wire

// *** jtsp_tap_core.sv ***
// Link side of the test access port: controller, scan registers, serial out.
// Assumes tck from the tester, tmsPin and tdiPin stable around tck rise.
`timescale 1ns/100ps
`default_nettype none
`include "jtsp_defs.svh"

module jtsp_tap_core #(
  parameter int BSR_LEN = `JTSP_BSR_LENGTH
) (
  input  wire logic                 tck,
  input  wire logic                 tmsPin,
  input  wire logic                 tdiPin,
  input  wire logic [BSR_LEN-1:0]   ringIn,
  output logic                      tdoOut,
  output logic                      tdoOeN,
  output logic [BSR_LEN-1:0]        ringOut,
  jtsp_xfer_if.link                 xfer
);

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  if (BSR_LEN != `JTSP_BSR_LENGTH) begin : gBadLen
    $error("Scan chain length must match the cell map");
  end

  // Power-up contents: reset state, identify selected, cell 47 high
  // identify at power-up
  function automatic jtsp_pkg::jtsp_link_t powerUp();
    jtsp_pkg::jtsp_link_t v;
    v = '0;
    v.state = jtsp_pkg::JTSP_RESET;
    v.irActive = `JTSP_INS_IDENT;
    v.bsrLatch[`JTSP_BSR_OE_CELL] = 1'b1;
    return v;
  endfunction

  // No reset pin on the link side: power-up values come from the declarations
  jtsp_pkg::jtsp_link_t s_reg = powerUp();
  jtsp_pkg::jtsp_link_t s_next;
  logic                 tdoNeg_reg = 1'b0;
  logic                 oeNeg_reg = 1'b1;
  logic                 serialBit;

  // Identification word, bit zero fixed high
  // field layout
  function automatic logic [`JTSP_ID_WIDTH-1:0] idWord();
    return {`JTSP_ID_REVISION, `JTSP_ID_PART, `JTSP_ID_MAKER, 1'b1};
  endfunction

  // Instruction selects the boundary chain
  function automatic logic selBsr(input logic [`JTSP_IR_WIDTH-1:0] ins);
    return (ins == `JTSP_INS_EXTERNAL) || (ins == `JTSP_INS_SAMPLE_HIZ) ||
           (ins == `JTSP_INS_SAMPLE);
  endfunction

  // ----------------------------------------------------------------------------
  // Next state of controller and registers
  // ----------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      jtsp_pkg::JTSP_RESET:     s_next.state = tmsPin ? jtsp_pkg::JTSP_RESET
                                                      : jtsp_pkg::JTSP_IDLE;
      jtsp_pkg::JTSP_IDLE:      s_next.state = tmsPin ? jtsp_pkg::JTSP_SEL_DR
                                                      : jtsp_pkg::JTSP_IDLE;
      jtsp_pkg::JTSP_SEL_DR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_SEL_IR
                                                      : jtsp_pkg::JTSP_CAP_DR;
      jtsp_pkg::JTSP_CAP_DR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT1_DR
                                                      : jtsp_pkg::JTSP_SHIFT_DR;
      jtsp_pkg::JTSP_SHIFT_DR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT1_DR
                                                      : jtsp_pkg::JTSP_SHIFT_DR;
      jtsp_pkg::JTSP_EXIT1_DR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_UPD_DR
                                                      : jtsp_pkg::JTSP_PAUSE_DR;
      jtsp_pkg::JTSP_PAUSE_DR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT2_DR
                                                      : jtsp_pkg::JTSP_PAUSE_DR;
      jtsp_pkg::JTSP_EXIT2_DR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_UPD_DR
                                                      : jtsp_pkg::JTSP_SHIFT_DR;
      jtsp_pkg::JTSP_UPD_DR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_SEL_DR
                                                      : jtsp_pkg::JTSP_IDLE;
      jtsp_pkg::JTSP_SEL_IR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_RESET
                                                      : jtsp_pkg::JTSP_CAP_IR;
      jtsp_pkg::JTSP_CAP_IR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT1_IR
                                                      : jtsp_pkg::JTSP_SHIFT_IR;
      jtsp_pkg::JTSP_SHIFT_IR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT1_IR
                                                      : jtsp_pkg::JTSP_SHIFT_IR;
      jtsp_pkg::JTSP_EXIT1_IR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_UPD_IR
                                                      : jtsp_pkg::JTSP_PAUSE_IR;
      jtsp_pkg::JTSP_PAUSE_IR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_EXIT2_IR
                                                      : jtsp_pkg::JTSP_PAUSE_IR;
      jtsp_pkg::JTSP_EXIT2_IR:  s_next.state = tmsPin ? jtsp_pkg::JTSP_UPD_IR
                                                      : jtsp_pkg::JTSP_SHIFT_IR;
      jtsp_pkg::JTSP_UPD_IR:    s_next.state = tmsPin ? jtsp_pkg::JTSP_SEL_DR
                                                      : jtsp_pkg::JTSP_IDLE;
      default:                  s_next.state = jtsp_pkg::JTSP_RESET;
    endcase

    // Register actions of the present state
    case (s_reg.state)
      jtsp_pkg::JTSP_RESET: begin
        s_next.irActive = `JTSP_INS_IDENT;
        s_next.bsrLatch[`JTSP_BSR_OE_CELL] = 1'b1;
      end
      jtsp_pkg::JTSP_CAP_IR: begin
        s_next.irShift = `JTSP_IR_CAPTURE;
      end
      jtsp_pkg::JTSP_SHIFT_IR: begin
        s_next.irShift = {tdiPin, s_reg.irShift[`JTSP_IR_WIDTH-1:1]};
      end
      jtsp_pkg::JTSP_UPD_IR: begin
        s_next.irActive = s_reg.irShift;
      end
      jtsp_pkg::JTSP_CAP_DR: begin
        if (s_reg.irActive == `JTSP_INS_IDENT) begin
          s_next.idShift = idWord();
        end
        if (selBsr(s_reg.irActive)) begin
          s_next.bsrShift = ringIn;
        end
        if (s_reg.irActive == `JTSP_INS_SKIP) begin
          s_next.skipBit = 1'b0;
        end
      end
      jtsp_pkg::JTSP_SHIFT_DR: begin
        if (s_reg.irActive == `JTSP_INS_IDENT) begin
          s_next.idShift = {tdiPin, s_reg.idShift[`JTSP_ID_WIDTH-1:1]};
        end else if (selBsr(s_reg.irActive)) begin
          s_next.bsrShift = {tdiPin, s_reg.bsrShift[BSR_LEN-1:1]};
        end else begin
          s_next.skipBit = tdiPin;
        end
      end
      jtsp_pkg::JTSP_UPD_DR: begin
        if (selBsr(s_reg.irActive)) begin
          s_next.bsrLatch = s_reg.bsrShift;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Link clock registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge tck) begin
    s_reg <= s_next;
  end

  // Serial source of the selected path
  always_comb begin
    if (s_reg.state == jtsp_pkg::JTSP_SHIFT_IR) begin
      serialBit = s_reg.irShift[0];
    end else if (s_reg.irActive == `JTSP_INS_IDENT) begin
      serialBit = s_reg.idShift[0];
    end else if (selBsr(s_reg.irActive)) begin
      serialBit = s_reg.bsrShift[0];
    end else begin
      serialBit = s_reg.skipBit;
    end
  end

  // ----------------------------------------------------------------------------
  // Falling edge output stage
  // ----------------------------------------------------------------------------
  // data out on fall
  always_ff @(negedge tck) begin
    tdoNeg_reg <= serialBit;
    oeNeg_reg  <= !((s_reg.state == jtsp_pkg::JTSP_SHIFT_IR) ||
                    (s_reg.state == jtsp_pkg::JTSP_SHIFT_DR));
  end

  assign tdoOut  = tdoNeg_reg;
  assign tdoOeN  = oeNeg_reg;
  assign ringOut = s_reg.bsrLatch;

  assign xfer.extestHiz = (s_reg.irActive == `JTSP_INS_SAMPLE_HIZ);
  assign xfer.extestOe  = (s_reg.irActive != `JTSP_INS_EXTERNAL) ||
                          s_reg.bsrLatch[`JTSP_BSR_OE_CELL];

endmodule

`default_nettype wire

// *** jtsp_tap_port.sv ***
// Top of the pin ring test access port.
// Assumes tck unrelated to clk; data out pin is three-stated by tdoOeN.
`timescale 1ns/100ps
`default_nettype none
`include "jtsp_defs.svh"

// Behaviour
// - Mode select is sampled on each rising test clock edge for next state.
// - Three-bit instruction, one-bit skip, 32-bit identity, 107-cell scan chain.
// - Identity word: revision 31:29, part 28:12, maker 11:1.
// - Identity bit zero always reads one.
// - Code 001 loads identity word and selects it, memory unaffected.
// - Code 010 captures ring, selects chain, forces memory outputs off.
// - Code 100 captures ring and selects chain, memory unaffected.
// - Code 111 selects the single skip bit, memory unaffected.
// - Code 000 is external test: captures ring and selects chain.
// - Reset loads identity instruction; capture loads 01 in low bits.
// - Data in taken on rising edge; data out changes on falling edge.
// - Cell 47 gates output bus under external test; presets high.
// - Skip bit is cleared when the skip instruction runs.
module jtsp_tap_port #(
  parameter int BSR_LEN = `JTSP_BSR_LENGTH
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 tck,
  input  wire logic                 tmsPin,
  input  wire logic                 tdiPin,
  input  wire logic [BSR_LEN-1:0]   ringIn,
  output logic                      tdoOut,
  output logic                      tdoOeN,
  output logic [BSR_LEN-1:0]        ringOut,
  output logic                      memOutHiz,
  output logic                      memOutDrive
);

  jtsp_xfer_if xfer ();

  jtsp_pkg::jtsp_sys_t y_reg;
  jtsp_pkg::jtsp_sys_t y_next;

  // ----------------------------------------------------------------------------
  // Link side core
  // ----------------------------------------------------------------------------
  // scan registers
  jtsp_tap_core #(
    .BSR_LEN (BSR_LEN)
  ) uCore (
    .tck     (tck),
    .tmsPin  (tmsPin),
    .tdiPin  (tdiPin),
    .ringIn  (ringIn),
    .tdoOut  (tdoOut),
    .tdoOeN  (tdoOeN),
    .ringOut (ringOut),
    .xfer    (xfer.link)
  );

  // Three stage crossing, change taken when stages two and three agree
  always_comb begin
    y_next = y_reg;
    y_next.hizSync = {y_reg.hizSync[1:0], xfer.extestHiz};
    y_next.oeSync  = {y_reg.oeSync[1:0], xfer.extestOe};
    if (y_reg.hizSync[2] == y_reg.hizSync[1]) begin
      y_next.outHiz = y_reg.hizSync[2];
    end
    if (y_reg.oeSync[2] == y_reg.oeSync[1]) begin
      y_next.outDrive = y_reg.oeSync[2];
    end
  end

  // ----------------------------------------------------------------------------
  // System clock registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      y_reg <= '{hizSync: 3'h0, outHiz: 1'b0, oeSync: 3'h7, outDrive: 1'b1};
    end else begin
      y_reg <= y_next;
    end
  end

  assign memOutHiz   = y_reg.outHiz;
  assign memOutDrive = y_reg.outDrive;

endmodule

`default_nettype wire

// *** jtsp_tap_port_properties.sv ***
// Checker of the pin ring test access port, bound to its top module.
// Assumes the tester holds tck low outside frames.
`timescale 1ns/100ps
`default_nettype none

module jtsp_tap_port_properties #(
  parameter int BSR_LEN = 107
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               tck,
  input wire logic               tmsPin,
  input wire logic               tdiPin,
  input wire logic [BSR_LEN-1:0] ringIn,
  input wire logic               tdoOut,
  input wire logic               tdoOeN,
  input wire logic [BSR_LEN-1:0] ringOut,
  input wire logic               memOutHiz,
  input wire logic               memOutDrive
);
  // ---------------------------------------------------------------------------
  // Shadow controller
  // ---------------------------------------------------------------------------
  localparam logic [63:0] N0 = 64'h1bddbba146644311;  // Next state, mode low
  localparam logic [63:0] N1 = 64'h2fefcc0287855920;  // Next state, mode high
  logic [3:0] st = 4'h0;
  logic [2:0] irSh = 3'h0;
  logic [2:0] irAct = 3'h1;

  // Tracks state and the active instruction
  always_ff @(posedge tck) begin
    st <= tmsPin ? N1[4*st +: 4] : N0[4*st +: 4];
    if (st == 4'hb) irSh <= {tdiPin, irSh[2:1]};
    if (st == 4'hf) irAct <= irSh;
    if (st == 4'h0) irAct <= 3'h1;
  end

  a_oe_shift: assert property (@(posedge tck)
    tdoOeN == !(st inside {4'h4, 4'hb})) else $error("tdo enable wrong");
  a_tdo_fall_only: assert property (@(posedge clk) disable iff (rst)
    $rose(tck) |-> $stable(tdoOut)) else $error("tdo moved at rise");
  a_ir_capture: assert property (@(posedge tck)
    st == 4'hb && $past(st) == 4'ha |-> tdoOut ##1 (st != 4'hb || !tdoOut))
    else $error("capture pattern wrong");
  a_id_lead: assert property (@(posedge tck)
    st == 4'h4 && $past(st) == 4'h3 && irAct == 3'h1 |-> tdoOut) else $error("id bit0 not 1");
  a_skip_lead: assert property (@(posedge tck)
    st == 4'h4 && $past(st) == 4'h3 && irAct == 3'h7 |-> !tdoOut) else $error("skip not 0");
  a_hiz_on: assert property (@(posedge clk) disable iff (rst)
    (irAct == 3'h2)[*8] |-> memOutHiz) else $error("hiz not set");
  a_hiz_off: assert property (@(posedge clk) disable iff (rst)
    (irAct != 3'h2)[*8] |-> !memOutHiz) else $error("hiz set wrongly");
  a_drive_gate: assert property (@(posedge clk) disable iff (rst)
    (irAct == 3'h0 && !ringOut[47])[*8] |-> !memOutDrive) else $error("bus not floated");
  a_ring_hold: assert property (@(posedge tck)
    $changed(ringOut) |-> st inside {4'h0, 4'h8} || $past(st) inside {4'h0, 4'h8})
    else $error("latch moved outside update");

  c_ir_update: cover property (@(posedge tck) st == 4'hf && irSh == 3'h2);
  c_float: cover property (@(posedge clk) !memOutDrive);
  c_hiz: cover property (@(posedge clk) memOutHiz);
endmodule

bind jtsp_tap_port jtsp_tap_port_properties #(.BSR_LEN(BSR_LEN)) u_props (
  .clk(clk), .rst(rst), .tck(tck), .tmsPin(tmsPin), .tdiPin(tdiPin), .ringIn(ringIn),
  .tdoOut(tdoOut), .tdoOeN(tdoOeN), .ringOut(ringOut), .memOutHiz(memOutHiz),
  .memOutDrive(memOutDrive));

`default_nettype wire

// *** jtsp_link_tester.sv ***
// Model of the external scan tester driving the four wire link.
// Assumes the port starts in test-logic-reset; tck stands low between frames.
`timescale 1ns/100ps
`default_nettype none

module jtsp_link_tester (
  output logic      tck,
  output logic      tmsPin,
  output logic      tdiPin,
  input  wire logic tdoOut
);
  initial begin
    tck = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b0;
  end

  // set up before rise, read out before rise
  // fixed six ns link cycle, no minimum needed by this logic
  task automatic step(input logic m, input logic d, output logic q);
    tmsPin = m;
    tdiPin = d;
    #1.5;
    q = tdoOut;
    tck = 1'b1;
    #3;
    tck = 1'b0;
    tdiPin = ~d;  // Stale data line shows inverse
    #1.5;
  endtask

  // Five mode highs, then idle
  task automatic goReset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // only defined codes are passed in
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

`default_nettype wire

// *** jtag_tap_scan_port_test.sv ***
// Self-checking bench of the pin ring test access port.
// Assumes the tester model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "jtsp_defs.svh"

module jtag_tap_scan_port_test;
  logic         clk, rst, tck, tmsPin, tdiPin, tdoOut, tdoOeN, memOutHiz, memOutDrive;
  logic [106:0] ringIn, ringOut;
  logic [127:0] d;
  logic [107:0] q = {27{4'h6}};
  logic [106:0] pat = {7'h5b, {25{4'hc}}};
  int           n_errors = 0;
  int           tests_run = 0;

  jtsp_tap_port dut (.clk(clk), .rst(rst), .tck(tck), .tmsPin(tmsPin), .tdiPin(tdiPin),
    .ringIn(ringIn), .tdoOut(tdoOut), .tdoOeN(tdoOeN), .ringOut(ringOut),
    .memOutHiz(memOutHiz), .memOutDrive(memOutDrive));
  jtsp_link_tester tester (.tck(tck), .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoOut(tdoOut));

  // System clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic mem(input logic hiz, input logic drv);
    repeat (10) @(posedge clk);
    #1;
    chk("memOutHiz", {127'h0, hiz}, {127'h0, memOutHiz});
    chk("memOutDrive", {127'h0, drv}, {127'h0, memOutDrive});
  endtask

  task automatic ld(input logic [2:0] c);
    tester.scan(1'b1, 3, {125'h0, c}, d);
  endtask

  task automatic readId();
    tester.scan(1'b0, 32, 128'h0, d);
    chk("idWord", {96'h0, `JTSP_ID_REVISION, `JTSP_ID_PART, `JTSP_ID_MAKER, 1'b1},
        {96'h0, d[31:0]});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_ident();
    tester.goReset();
    readId();
    ld(3'h7);
    chk("irCapture", 128'h1, {126'h0, d[1:0]});
    tester.goReset();
    readId();
    mem(1'b0, 1'b1);
    $display("t_ident done");
  endtask

  task automatic t_skip();
    ld(3'h7);
    tester.scan(1'b0, 8, 128'ha5, d);
    chk("skipPath", 128'h4a, d);
    tester.scan(1'b0, 8, 128'ha5, d);
    chk("skipCleared", 128'h4a, d);
    mem(1'b0, 1'b1);
    $display("t_skip done");
  endtask

  task automatic t_sample();
    ld(3'h4);
    tester.scan(1'b0, 108, {20'h0, q}, d);
    chk("ringCapture", {21'h0, pat}, d);
    chk("ringOut", {21'h0, q[107:1]}, {21'h0, ringOut});
    mem(1'b0, 1'b1);
    $display("t_sample done");
  endtask

  task automatic t_extest();
    ld(3'h0);
    mem(1'b0, 1'b0);
    tester.scan(1'b0, 107, {20'h0, q}, d);
    chk("extestCapture", {21'h0, pat}, d);
    @(posedge clk);
    #1 ringIn = ~pat;
    ld(3'h2);
    mem(1'b1, 1'b1);
    tester.scan(1'b0, 107, {20'h0, q}, d);
    chk("hizCapture", {21'h0, ~pat}, d);
    tester.goReset();
    mem(1'b0, 1'b1);
    chk("presetCell", 128'h1, {127'h0, ringOut[47]});
    $display("t_extest done");
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    ringIn = pat;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_ident();
    t_skip();
    t_sample();
    t_extest();
    end_of_test();
  end

  // Watchdog
  initial begin
    #30000;
    n_errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
